/* File: src/rrdr_top.sv */
/*
 * radio relay defect reporting: turns radio path conditions into the
 * radio, protection and overhead access report points, inserts the
 * all-ones alarm toward the multiplex side and handles the reduced-rate
 * section overhead (regenerator termination, protection channel).
 * assumes condition pins asynchronous to i_clock, a byte stream on
 * i_clock with a start of frame marker, and a static configuration.
 */
`timescale 1ns/1ps
module rrdr_top (
	// clock and reset
	input  wire logic                      i_clock,
	input  wire logic                      i_rst,
	// radio path condition pins
	input  wire rrdr_pkg::rrdr_raw_t       i_raw,
	input  wire logic [rrdr_pkg::NCHAN-1:0] i_chan_unprot,
	// configuration
	input  wire rrdr_pkg::rrdr_opt_t       i_opt_en,
	input  wire rrdr_pkg::rrdr_sure_t      i_sure,
	input  wire logic                      i_regen_mode,
	input  wire rrdr_pkg::rrdr_chan_sel_t  i_prot_sel,
	input  wire logic                      i_rbe_in_rcoh,
	// receive byte stream
	input  wire logic                      i_rx_valid,
	input  wire logic                      i_rx_sof,
	input  wire logic [7:0]                i_rx_byte,
	input  wire logic [7:0]                i_local_rsoh,
	input  wire logic [7:0]                i_prot_tx_byte,
	// report points
	output rrdr_pkg::rrdr_radio_rpt_t      o_radio_rpt,
	output rrdr_pkg::rrdr_prot_rpt_t       o_prot_rpt,
	output rrdr_pkg::rrdr_oh_rpt_t         o_oh_rpt,
	// multiplex side byte stream
	output logic                           o_ms_valid,
	output logic [7:0]                     o_ms_byte,
	output logic                           o_msoh_stb,
	output logic                           o_ais,
	// complementary overhead
	output logic                           o_rcoh_valid,
	output logic                           o_rcoh_rbe,
	output logic [7:0]                     o_rcoh_byte
);

	// ****************************************************************
	// state and helpers
	// ****************************************************************
	typedef struct packed {
		rrdr_pkg::rrdr_radio_rpt_t radio;     // radio report point
		rrdr_pkg::rrdr_prot_rpt_t  prot;      // protection report point
		rrdr_pkg::rrdr_oh_rpt_t    oh;        // overhead access report point
		logic [rrdr_pkg::ROW_W-1:0] row;      // next byte row
		logic [rrdr_pkg::COL_W-1:0] col;      // next byte column
		logic                      ms_valid;  // output byte valid
		logic [7:0]                ms_byte;   // output byte
		logic                      msoh_stb;  // multiplex overhead extracted
		logic                      ais;       // alarm fill active
		logic                      rcoh_valid;
		logic                      rcoh_rbe;  // byte is block error count
		logic [7:0]                rcoh_byte;
	} rrdr_state_t;

	rrdr_state_t q;                            // registered state
	rrdr_state_t d;                            // next state

	rrdr_pkg::rrdr_raw_t           c;          // synchronised conditions
	logic [rrdr_pkg::NCHAN-1:0]    u;          // synchronised unprotected

	// true when (row, col) sits on the given overhead slot
	function automatic logic at_slot(
		input logic [rrdr_pkg::ROW_W-1:0] row,
		input logic [rrdr_pkg::COL_W-1:0] col,
		input logic [rrdr_pkg::ROW_W-1:0] srow,
		input logic [rrdr_pkg::COL_W-1:0] scol
	);
		return (row == srow) && (col == scol);
	endfunction

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	rrdr_sync #(
		.W($bits(rrdr_pkg::rrdr_raw_t) + rrdr_pkg::NCHAN)
	) u_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_pin   ({i_raw, i_chan_unprot}),
		.o_level ({c, u})
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic                       rx_def;     // any receive side condition
		logic [rrdr_pkg::ROW_W-1:0] row;        // position of this byte
		logic [rrdr_pkg::COL_W-1:0] col;
		logic [7:0]                 obyte;      // byte after overhead handling
		logic                       in_oh;
		logic                       rsoh;
		logic                       msoh;
		logic                       prot_slot;
		rx_def    = 1'b0;
		row       = '0;
		col       = '0;
		obyte     = 8'h00;
		in_oh     = 1'b0;
		rsoh      = 1'b0;
		msoh      = 1'b0;
		prot_slot = 1'b0;
		d         = q;

		// modulator side indications
		d.radio.modulator_input_loss = i_opt_en.mod & c.mod_in_loss;
		d.radio.modulator_fault      = c.mod_internal | c.mod_in_loss;

		// transmitter: unsure loss folds into the fault
		d.radio.transmitter_fault      = c.tx_internal
			| (c.tx_in_loss & ~i_sure.tx);
		d.radio.transmitter_input_loss = i_opt_en.tx & i_sure.tx
			& c.tx_in_loss;

		// receiver: same preference for the fault
		d.radio.receiver_fault      = c.rx_internal
			| (c.rx_in_loss & ~i_sure.rx);
		d.radio.receiver_input_loss = i_opt_en.rx & i_sure.rx
			& c.rx_in_loss;

		// demodulator
		d.radio.demodulator_fault      = c.dem_internal
			| (c.dem_in_loss & ~i_sure.dem);
		d.radio.demodulator_input_loss = i_opt_en.dem & i_sure.dem
			& c.dem_in_loss;

		// protection report, local channels only
		d.prot.unprotected             = u;
		d.prot.protection_switch_fault = |u;

		// alarm fill follows the receive conditions, not their reporting
		rx_def = c.rx_in_loss | c.rx_internal | c.dem_in_loss
			| c.dem_internal;
		d.ais  = rx_def;

		// one-cycle outputs drop unless set below
		d.ms_valid       = i_rx_valid;
		d.msoh_stb       = 1'b0;
		d.rcoh_valid     = 1'b0;
		d.rcoh_rbe       = 1'b0;
		d.oh.prot_rx_new = 1'b0;

		// byte handling
		if (i_rx_valid) begin
			// locate the byte; start of frame forces the origin
			if (i_rx_sof) begin
				row           = '0;
				col           = '0;
				d.oh.frame_seen = 1'b1;
			end else begin
				row = q.row;
				col = q.col;
			end
			obyte = i_rx_byte;

			// only columns of the reduced frame carry overhead
			in_oh = col < rrdr_pkg::OH_COLS;
			rsoh  = in_oh && (row < rrdr_pkg::RSOH_ROWS);
			msoh  = in_oh && (row > rrdr_pkg::PTR_ROW);

			// protection slot never falls on K1 or K2
			prot_slot = ((i_prot_sel == rrdr_pkg::RRDR_CH_C1)
					&& at_slot(row, col, rrdr_pkg::C1_ROW, rrdr_pkg::C1_COL))
				|| ((i_prot_sel == rrdr_pkg::RRDR_CH_F1)
					&& at_slot(row, col, rrdr_pkg::F1_ROW, rrdr_pkg::F1_COL));

			// regenerator rebuilds its own section overhead
			if (i_regen_mode && rsoh) begin
				obyte = i_local_rsoh;
			end

			// protection channel in C1 or F1: extract, then reinsert
			if (prot_slot) begin
				d.oh.prot_rx_byte = i_rx_byte;
				d.oh.prot_rx_new  = 1'b1;
				obyte             = i_prot_tx_byte;
			end

			// terminal terminates multiplex overhead; regenerator passes it
			if (!i_regen_mode && msoh) begin
				d.msoh_stb = 1'b1;
			end

			// complementary overhead: block error, else protection byte
			if (i_rbe_in_rcoh
				&& at_slot(row, col, rrdr_pkg::M1_ROW, rrdr_pkg::M1_COL)) begin
				d.rcoh_valid = 1'b1;
				d.rcoh_rbe   = 1'b1;
				d.rcoh_byte  = i_rx_byte;
			end else if ((i_prot_sel == rrdr_pkg::RRDR_CH_RCOH) && i_rx_sof) begin
				d.rcoh_valid = 1'b1;
				d.rcoh_byte  = i_prot_tx_byte;
			end

			// pointer row and payload pass untouched, no grouping
			d.ms_byte = rx_def ? rrdr_pkg::AIS_BYTE : obyte;

			// advance position
			if (col == rrdr_pkg::FRAME_COLS - 7'h01) begin
				d.col = '0;
				if (row == rrdr_pkg::FRAME_ROWS - 4'h1) begin
					d.row = '0;
				end else begin
					d.row = row + 4'h1;
				end
			end else begin
				d.col = col + 7'h01;
				d.row = row;
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs, each straight from the state register
	// ****************************************************************
	assign o_radio_rpt  = q.radio;
	assign o_prot_rpt   = q.prot;
	assign o_oh_rpt     = q.oh;
	assign o_ms_valid   = q.ms_valid;
	assign o_ms_byte    = q.ms_byte;
	assign o_msoh_stb   = q.msoh_stb;
	assign o_ais        = q.ais;
	assign o_rcoh_valid = q.rcoh_valid;
	assign o_rcoh_rbe   = q.rcoh_rbe;
	assign o_rcoh_byte  = q.rcoh_byte;

	// ****************************************************************
	// assertions
	// ****************************************************************
	logic [rrdr_pkg::ROW_W-1:0] chk_row;    // position of the incoming byte
	logic [rrdr_pkg::COL_W-1:0] chk_col;
	assign chk_row = i_rx_sof ? '0 : q.row;
	assign chk_col = i_rx_sof ? '0 : q.col;

	// modulator input loss always raises the modulator fault
	property p_mod_fault;
		@(posedge i_clock) disable iff (i_rst)
		c.mod_in_loss |=> o_radio_rpt.modulator_fault;
	endproperty
	a_mod_fault: assert property (p_mod_fault)
		else $error("modulator fault missing on input loss");

	// optional indication stays low while disabled
	property p_mod_opt;
		@(posedge i_clock) disable iff (i_rst)
		!i_opt_en.mod |=> !o_radio_rpt.modulator_input_loss;
	endproperty
	a_mod_opt: assert property (p_mod_opt)
		else $error("disabled modulator input loss raised");

	// unsure transmitter loss shows as fault, never as loss
	property p_tx_pref;
		@(posedge i_clock) disable iff (i_rst)
		(c.tx_in_loss && !i_sure.tx)
			|=> (o_radio_rpt.transmitter_fault && !o_radio_rpt.transmitter_input_loss);
	endproperty
	a_tx_pref: assert property (p_tx_pref)
		else $error("unsure transmitter loss not folded into fault");

	// unsure receiver loss shows as fault
	property p_rx_pref;
		@(posedge i_clock) disable iff (i_rst)
		(c.rx_in_loss && !i_sure.rx)
			|=> (o_radio_rpt.receiver_fault && !o_radio_rpt.receiver_input_loss);
	endproperty
	a_rx_pref: assert property (p_rx_pref)
		else $error("unsure receiver loss not folded into fault");

	// unsure demodulator loss shows as fault
	property p_dem_pref;
		@(posedge i_clock) disable iff (i_rst)
		(c.dem_in_loss && !i_sure.dem)
			|=> (o_radio_rpt.demodulator_fault && !o_radio_rpt.demodulator_input_loss);
	endproperty
	a_dem_pref: assert property (p_dem_pref)
		else $error("unsure demodulator loss not folded into fault");

	// fault clears on the first clock after both causes end
	property p_tx_clear;
		@(posedge i_clock) disable iff (i_rst)
		(!c.tx_internal && !c.tx_in_loss) |=> !o_radio_rpt.transmitter_fault;
	endproperty
	a_tx_clear: assert property (p_tx_clear)
		else $error("transmitter fault held after condition ended");

	// internal receive fault fills every valid output byte with ones
	property p_ais_fill;
		@(posedge i_clock) disable iff (i_rst)
		(i_rx_valid && c.rx_internal) |=> (o_ais && o_ms_byte == rrdr_pkg::AIS_BYTE);
	endproperty
	a_ais_fill: assert property (p_ais_fill)
		else $error("alarm fill missing on receive fault");

	// transmit indications alone never fill
	property p_no_tx_ais;
		@(posedge i_clock) disable iff (i_rst)
		o_ais |-> ($past(c.rx_in_loss) || $past(c.rx_internal)
			|| $past(c.dem_in_loss) || $past(c.dem_internal));
	endproperty
	a_no_tx_ais: assert property (p_no_tx_ais)
		else $error("alarm fill without receive condition");

	// K1 and K2 leave unchanged when no alarm fill
	property p_k_pass;
		@(posedge i_clock) disable iff (i_rst)
		(i_rx_valid && !d.ais && chk_row == rrdr_pkg::K_ROW
			&& (chk_col == rrdr_pkg::K1_COL || chk_col == rrdr_pkg::K2_COL))
			|=> (o_ms_byte == $past(i_rx_byte));
	endproperty
	a_k_pass: assert property (p_k_pass)
		else $error("K1 or K2 altered");

	// regenerator passes multiplex overhead unchanged
	property p_regen_msoh;
		@(posedge i_clock) disable iff (i_rst)
		(i_rx_valid && i_regen_mode && !d.ais && chk_col < rrdr_pkg::OH_COLS
			&& chk_row > rrdr_pkg::PTR_ROW)
			|=> (o_ms_byte == $past(i_rx_byte) && !o_msoh_stb);
	endproperty
	a_regen_msoh: assert property (p_regen_msoh)
		else $error("regenerator altered multiplex overhead");

	// an unprotected channel raises the protection fault
	property p_prot_fault;
		@(posedge i_clock) disable iff (i_rst)
		(|u) |=> o_prot_rpt.protection_switch_fault;
	endproperty
	a_prot_fault: assert property (p_prot_fault)
		else $error("protection fault missing");

	// main scenarios
	c_ais_frame:  cover property (@(posedge i_clock) disable iff (i_rst)
		o_ais && o_ms_valid);
	c_prot_c1:    cover property (@(posedge i_clock) disable iff (i_rst)
		o_oh_rpt.prot_rx_new);
	c_rbe_rcoh:   cover property (@(posedge i_clock) disable iff (i_rst)
		o_rcoh_valid && o_rcoh_rbe);
	c_prot_fault: cover property (@(posedge i_clock) disable iff (i_rst)
		o_prot_rpt.protection_switch_fault);

endmodule

/* File: src/rrdr_pkg.sv */
/*
 * constants, field layouts and carrier structs for the radio relay defect
 * reporting block: frame geometry of the reduced-rate frame, overhead slot
 * positions, the alarm fill byte and the report point structs.
 * assumes one 50 MHz clock and that every user includes nothing: all uses
 * are written rrdr_pkg::name.
 */
// Behaviour
// - optional modulator input loss when input data lost
// - modulator fault on internal fault or input loss
// - transmitter fault on internal transmit fault
// - optional transmitter input loss indication
// - unsure transmitter loss reported as transmitter fault
// - optional receiver input loss; unsure means fault
// - receiver fault on internal receive fault
// - optional demodulator input loss indication
// - unsure demodulator loss reported as demodulator fault
// - demodulator fault on internal demodulator fault
// - radio, protection, overhead reports on separate points
// - never use K1/K2 for radio protection
// - protection channel in complementary overhead, C1, F1
// - regenerator terminates RSOH, passes MSOH unchanged
// - process only overhead columns of reduced frame
// - no administrative unit grouping in adaptation
// - equipment interface carries 51.84 Mbit/s frame
// - remote block error carried in complementary overhead
// - protection works independently per interface side
// - receive indications insert all-ones toward multiplex side
// - protection fault when a channel is unprotected
package rrdr_pkg;

	// ****************************************************************
	// frame geometry
	// ****************************************************************
	localparam int          ROW_W          = 4;            // row counter width
	localparam int          COL_W          = 7;            // column counter width
	localparam logic [3:0]  FRAME_ROWS     = 4'h9;         // rows per frame
	localparam logic [6:0]  FRAME_COLS     = 7'h5A;        // columns per row
	localparam logic [6:0]  OH_COLS        = 7'h03;        // overhead columns present
	localparam logic [3:0]  RSOH_ROWS      = 4'h3;         // regenerator overhead rows
	localparam logic [3:0]  PTR_ROW        = 4'h3;         // pointer row, passes through
	localparam int          LINK_RATE_KBPS = 51_840;       // equipment interface rate

	// ****************************************************************
	// overhead slot positions (row, column)
	// ****************************************************************
	localparam logic [3:0]  C1_ROW = 4'h0;
	localparam logic [6:0]  C1_COL = 7'h02;
	localparam logic [3:0]  F1_ROW = 4'h1;
	localparam logic [6:0]  F1_COL = 7'h02;
	localparam logic [3:0]  K_ROW  = 4'h4;
	localparam logic [6:0]  K1_COL = 7'h01;
	localparam logic [6:0]  K2_COL = 7'h02;
	localparam logic [3:0]  M1_ROW = 4'h8;
	localparam logic [6:0]  M1_COL = 7'h01;

	// ****************************************************************
	// fill values and widths
	// ****************************************************************
	localparam logic [7:0]  AIS_BYTE   = 8'hFF;           // all-ones alarm fill
	localparam int          NCHAN      = 4;               // protected channels
	localparam int          SYNC_DEPTH = 3;               // pin synchroniser stages

	// protection channel carrier selection
	typedef enum logic [1:0] {
		RRDR_CH_NONE,
		RRDR_CH_RCOH,
		RRDR_CH_C1,
		RRDR_CH_F1
	} rrdr_chan_sel_t;

	// raw condition inputs from the radio path
	typedef struct packed {
		logic mod_in_loss;
		logic mod_internal;
		logic tx_in_loss;
		logic tx_internal;
		logic rx_in_loss;
		logic rx_internal;
		logic dem_in_loss;
		logic dem_internal;
	} rrdr_raw_t;

	// enables of the optional indications
	typedef struct packed {
		logic mod;
		logic tx;
		logic rx;
		logic dem;
	} rrdr_opt_t;

	// loss can be told from internal fault with confidence
	typedef struct packed {
		logic tx;
		logic rx;
		logic dem;
	} rrdr_sure_t;

	// radio interface report point
	typedef struct packed {
		logic modulator_input_loss;
		logic modulator_fault;
		logic transmitter_fault;
		logic transmitter_input_loss;
		logic receiver_input_loss;
		logic receiver_fault;
		logic demodulator_input_loss;
		logic demodulator_fault;
	} rrdr_radio_rpt_t;

	// protection report point
	typedef struct packed {
		logic             protection_switch_fault;
		logic [NCHAN-1:0] unprotected;
	} rrdr_prot_rpt_t;

	// overhead access report point
	typedef struct packed {
		logic       frame_seen;
		logic       prot_rx_new;
		logic [7:0] prot_rx_byte;
	} rrdr_oh_rpt_t;

endpackage

/* File: src/rrdr_sync.sv */
/*
 * three stage synchroniser for a vector of pin levels; the output takes a
 * new value only once the second and third stages agree.
 * assumes inputs that are asynchronous to i_clock.
 */
`timescale 1ns/1ps
module rrdr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	// pin levels in, filtered level out
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [W-1:0] s1;     // first stage, read only by s2
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;    // accepted level
	} rrdr_sync_st_t;

	rrdr_sync_st_t q;         // registered state
	rrdr_sync_st_t d;         // next state

	// shift and accept agreeing bits
	always_comb begin
		d     = q;
		d.s1  = i_pin;
		d.s2  = q.s1;
		d.s3  = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.lvl[i] = q.s3[i];
			end
		end
	end

	// register the whole state
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_level = q.lvl;

endmodule

/* File: sim/rrdr_mgmt.sv */
/*
 * management side model: takes the three report points and counts the edges on
 * which any radio or protection indication or frame_seen rises. assumes registered report levels on i_clock.
 */
`timescale 1ns/1ps
module rrdr_mgmt (
	// clock and reset
	input  wire logic                      i_clock,
	input  wire logic                      i_rst,
	// report points
	input  wire rrdr_pkg::rrdr_radio_rpt_t i_radio,
	input  wire rrdr_pkg::rrdr_prot_rpt_t  i_prot,
	input  wire rrdr_pkg::rrdr_oh_rpt_t    i_oh,
	// edges with a raised indication so far
	output logic [15:0]                    o_events
);
	logic [13:0] last_q; // levels seen last edge
	logic [13:0] now_v;  // radio and protection levels plus frame_seen
	assign now_v = {i_radio, i_prot, i_oh.frame_seen};
	// count one per edge on which any level rises
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			last_q   <= '0;
			o_events <= '0;
		end else begin
			last_q   <= now_v;
			o_events <= o_events + 16'(|(now_v & ~last_q));
		end
	end
endmodule

/* File: sim/rrdr_top_tb.sv */
/*
 * bench for rrdr_top: random pins and configuration against expected
 * reports, then whole frames through the byte path. assumes rrdr_mgmt.
 */
`timescale 1ns/1ps
module rrdr_top_tb;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic                      i_clock, i_rst, i_regen_mode, i_rbe_in_rcoh;
	logic                      i_rx_valid, i_rx_sof, o_ms_valid, o_msoh_stb, o_ais;
	logic                      o_rcoh_valid, o_rcoh_rbe;
	logic [7:0]                i_rx_byte, i_local_rsoh, i_prot_tx_byte, o_ms_byte, o_rcoh_byte;
	logic [3:0]                i_chan_unprot;
	logic [15:0]               ev;
	rrdr_pkg::rrdr_raw_t       i_raw;
	rrdr_pkg::rrdr_opt_t       i_opt_en;
	rrdr_pkg::rrdr_sure_t      i_sure;
	rrdr_pkg::rrdr_chan_sel_t  i_prot_sel;
	rrdr_pkg::rrdr_radio_rpt_t o_radio_rpt;
	rrdr_pkg::rrdr_prot_rpt_t  o_prot_rpt;
	rrdr_pkg::rrdr_oh_rpt_t    o_oh_rpt;
	int                        bad_count = 0;
	int                        cmp_count = 0;

	rrdr_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_raw(i_raw), .i_chan_unprot(i_chan_unprot),
		.i_opt_en(i_opt_en), .i_sure(i_sure), .i_regen_mode(i_regen_mode),
		.i_prot_sel(i_prot_sel), .i_rbe_in_rcoh(i_rbe_in_rcoh), .i_rx_valid(i_rx_valid),
		.i_rx_sof(i_rx_sof), .i_rx_byte(i_rx_byte), .i_local_rsoh(i_local_rsoh),
		.i_prot_tx_byte(i_prot_tx_byte), .o_radio_rpt(o_radio_rpt), .o_prot_rpt(o_prot_rpt),
		.o_oh_rpt(o_oh_rpt), .o_ms_valid(o_ms_valid), .o_ms_byte(o_ms_byte),
		.o_msoh_stb(o_msoh_stb), .o_ais(o_ais), .o_rcoh_valid(o_rcoh_valid),
		.o_rcoh_rbe(o_rcoh_rbe), .o_rcoh_byte(o_rcoh_byte));
	rrdr_mgmt mgmt (.i_clock(i_clock), .i_rst(i_rst), .i_radio(o_radio_rpt),
		.i_prot(o_prot_rpt), .i_oh(o_oh_rpt), .o_events(ev));

	always #10 i_clock = ~i_clock; // 50 MHz

	// ****************************************************************
	// compares, expectations, verdict
	// ****************************************************************
	task automatic chk_ind(logic [15:0] got, logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t flags got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// radio report expected from pins and configuration
	function automatic logic [7:0] exp_rpt(rrdr_pkg::rrdr_raw_t r);
		return {i_opt_en.mod & r.mod_in_loss, r.mod_internal | r.mod_in_loss,
			r.tx_internal | (r.tx_in_loss & ~i_sure.tx), i_opt_en.tx & i_sure.tx & r.tx_in_loss,
			i_opt_en.rx & i_sure.rx & r.rx_in_loss, r.rx_internal | (r.rx_in_loss & ~i_sure.rx),
			i_opt_en.dem & i_sure.dem & r.dem_in_loss,
			r.dem_internal | (r.dem_in_loss & ~i_sure.dem)};
	endfunction
	// protection slot of the selected carrier
	function automatic bit is_prot(int r, int c);
		return c == 2 && ((i_prot_sel == rrdr_pkg::RRDR_CH_C1 && r == 0) ||
			(i_prot_sel == rrdr_pkg::RRDR_CH_F1 && r == 1));
	endfunction
	function automatic logic [7:0] exp_byte(int r, int c, logic [7:0] b);
		if (|i_raw[3:0]) return 8'hFF;
		if (is_prot(r, c)) return i_prot_tx_byte;
		if (i_regen_mode && r < 3 && c < 3) return i_local_rsoh;
		return b;
	endfunction
	// one whole frame back to back, outputs one edge behind
	task automatic run_frame();
		int         r, c;
		logic [7:0] b, eb, er;
		logic [4:0] ef;
		for (int n = 0; n <= 810; n++) begin
			@(posedge i_clock);
			#1;
			if (n > 0) begin
				chk_byte(o_ms_byte, eb);
				chk_ind({o_ms_valid, o_msoh_stb, o_rcoh_valid, o_rcoh_valid & o_rcoh_rbe,
					o_oh_rpt.prot_rx_new}, ef);
				if (ef[0]) chk_byte(o_oh_rpt.prot_rx_byte, b);
				if (ef[2]) chk_byte(o_rcoh_byte, er);
			end
			if (n < 810) begin
				r = n / 90;
				c = n % 90;
				b = 8'($urandom);
				i_rx_valid = 1'b1;
				i_rx_sof = (n == 0);
				i_rx_byte = b;
				eb = exp_byte(r, c, b);
				ef = {1'b1, !i_regen_mode && r >= 4 && c < 3,
					(i_rbe_in_rcoh && r == 8 && c == 1) ||
					(i_prot_sel == rrdr_pkg::RRDR_CH_RCOH && n == 0),
					i_rbe_in_rcoh && r == 8 && c == 1, is_prot(r, c)};
				er = ef[1] ? b : i_prot_tx_byte;
			end else i_rx_valid = 1'b0;
		end
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(88));
		{i_clock, i_rst, i_raw, i_chan_unprot, i_opt_en, i_sure} = {2'b01, 19'h0_0000};
		{i_regen_mode, i_rbe_in_rcoh, i_rx_valid, i_rx_sof} = 4'h0;
		{i_rx_byte, i_local_rsoh, i_prot_tx_byte} = 24'h00_0000;
		i_prot_sel = rrdr_pkg::RRDR_CH_NONE;
		repeat (20) @(posedge i_clock);
		#1 i_rst = 1'b0;
		chk_ind({o_radio_rpt, o_prot_rpt, o_ais}, 16'h0000);
		// random pin sets, all-ones corner first
		for (int k = 0; k < 40; k++) begin
			i_raw = (k == 0) ? 8'hFF : 8'($urandom);
			i_chan_unprot = (k == 0) ? 4'h1 : 4'($urandom);
			i_opt_en = 4'($urandom);
			i_sure = 3'($urandom);
			repeat (6) @(posedge i_clock);
			#1;
			chk_ind(o_radio_rpt, exp_rpt(i_raw));
			chk_ind(o_ais, |i_raw[3:0]);
			chk_ind(o_prot_rpt, {|i_chan_unprot, i_chan_unprot});
		end
		// conditions end, every level drops
		i_raw = 8'h00;
		i_chan_unprot = 4'h0;
		repeat (5) @(posedge i_clock);
		#1;
		chk_ind({o_radio_rpt, o_prot_rpt, o_ais}, 16'h0000);
		// every carrier code, both modes, block error option
		for (int m = 0; m < 4; m++) begin
			i_regen_mode = m[0];
			i_rbe_in_rcoh = m[1];
			i_prot_sel = rrdr_pkg::rrdr_chan_sel_t'(2'(m));
			i_local_rsoh = 8'($urandom);
			i_prot_tx_byte = 8'($urandom);
			run_frame();
		end
		chk_ind(o_oh_rpt.frame_seen, 1'b1);
		// receive fault fills the whole stream
		i_raw = 8'h04;
		i_prot_sel = rrdr_pkg::RRDR_CH_NONE;
		i_rbe_in_rcoh = 1'b0;
		repeat (6) @(posedge i_clock);
		run_frame();
		chk_ind(ev != 16'h0000, 1'b1);
		wrap_up();
	end

	// hang guard, about five times the expected run
	initial begin
		#400_000;
		bad_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
